// *** twi_pkg.sv ***
// constants shared by the two-wire slave port
package twi_pkg;
   // device identifier nibble in the upper bits of the first byte (arbitrary)
   localparam logic [3:0] DEV_ID_DEFAULT = 4'hb;
   localparam int         ADDR_BITS      = 3;
   localparam int         BYTE_BITS      = 8;
   localparam logic [3:0] BIT_LAST       = 4'h7;
   localparam logic [3:0] BIT_ACK        = 4'h8;
   localparam logic [3:0] BIT_FIRST      = 4'h0;
   // master bus rates the port is built for, and the system clock
   localparam int         STD_RATE_KHZ   = 100;
   localparam int         FAST_RATE_KHZ  = 400;
   localparam int         SYS_CLK_MHZ    = 250;
   // system cycles per half period of fast scl, must exceed sync latency
   localparam int         FAST_HALF_CYC  = (SYS_CLK_MHZ * 1000) /
                                           (FAST_RATE_KHZ * 2);
   localparam int         SYNC_LAT_CYC   = 3;
endpackage

// *** twi_line_sync.sv ***
// two-stage synchroniser with edge detection for scl and sda
`timescale 1ns/1ps
`default_nettype none
module twi_line_sync (
   // clock and reset
   input  wire logic sys_clk_i,
   input  wire logic rst_i,
   // raw line
   input  wire logic line_i,
   // synchronised level and edges
   output logic      level_o,
   output logic      rise_o,
   output logic      fall_o
);
   logic meta_reg;
   logic meta_next;
   logic sync_reg;
   logic sync_next;
   logic last_reg;
   logic last_next;

   always_comb begin
      meta_next = line_i;
      sync_next = meta_reg;
      last_next = sync_reg;
   end

   // idle bus is high, so reset to one
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         meta_reg <= 1'b1;
         sync_reg <= 1'b1;
         last_reg <= 1'b1;
      end else begin
         meta_reg <= meta_next;
         sync_reg <= sync_next;
         last_reg <= last_next;
      end
   end

   assign level_o = last_reg;
   assign rise_o  = sync_reg & ~last_reg;
   assign fall_o  = ~sync_reg & last_reg;
endmodule
`default_nettype wire

// *** two_wire_slave_port.sv ***
// two-wire bus slave port with address match and eeprom-busy refusal
`timescale 1ns/1ps
`default_nettype none
// Contract
// - bytes per transfer are unlimited; the master decides the count.
// - data moves in bytes; the receiver acknowledges in a ninth slot.
// - port works with 100 kHz and 400 kHz master clocks.
// - an addressed receiver acknowledges each full byte.
// - acknowledger holds sda low over the whole ack clock high phase.
// - during eeprom write every request gets not-acknowledge.
// - after master not-acknowledge the device releases sda high.
// - in writes, address then data; device acknowledges every byte.
// - transfer ends by stop or repeated start; repeated start restarts.
// - start and stop frame transfers; address compared after first byte.
// - on read direction the device drives data on sda.
// - first byte is identifier, programmable address and direction bit.
// - three address-select bits allow eight devices on one bus.
// - sda falling with scl high is start, rising is stop.
// - sda changes only while scl low; one clock pulse per bit.
// - with eeprom write control clear, register writes start eeprom busy.
module two_wire_slave_port #(
   parameter logic [3:0] DEV_ID = twi_pkg::DEV_ID_DEFAULT
) (
   // clock and reset
   input  wire logic       sys_clk_i,
   input  wire logic       rst_i,
   // bus pins; scl is input only
   input  wire logic       scl_i,
   input  wire logic       sda_i,
   output logic            sda_o,
   output logic            sda_oe_o,
   // configuration
   input  wire logic [2:0] address_select_bits_i,
   input  wire logic       eeprom_write_control_i,
   input  wire logic       eeprom_busy_i,
   // register side
   output logic            wr_stb_o,
   output logic [7:0]      wr_data_o,
   output logic            first_o,
   output logic            rd_stb_o,
   input  wire logic [7:0] rd_data_i,
   output logic            eeprom_start_o
);
   typedef enum {ST_IDLE, ST_ADDR, ST_RX, ST_TX, ST_ACK_RX, ST_ACK_TX,
                 ST_IGNORE} state_t;

   logic scl_lvl;
   logic scl_rise;
   logic scl_fall;
   logic sda_lvl;
   logic sda_rise;
   logic sda_fall;

   // synchronised sampling keeps far above 400 kHz edge spacing
   twi_line_sync u_scl_sync (
      .sys_clk_i (sys_clk_i),
      .rst_i     (rst_i),
      .line_i    (scl_i),
      .level_o   (scl_lvl),
      .rise_o    (scl_rise),
      .fall_o    (scl_fall)
   );

   twi_line_sync u_sda_sync (
      .sys_clk_i (sys_clk_i),
      .rst_i     (rst_i),
      .line_i    (sda_i),
      .level_o   (sda_lvl),
      .rise_o    (sda_rise),
      .fall_o    (sda_fall)
   );

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   state_t     state_reg;
   state_t     state_next;
   logic [3:0] bit_reg;
   logic [3:0] bit_next;
   logic [7:0] shift_reg;
   logic [7:0] shift_next;
   logic       ack_reg;
   logic       ack_next;
   logic       sda_oe_reg;
   logic       sda_oe_next;
   logic       wr_stb_reg;
   logic       wr_stb_next;
   logic [7:0] wr_data_reg;
   logic [7:0] wr_data_next;
   logic       first_reg;
   logic       first_next;
   logic       first_pend_reg;
   logic       first_pend_next;
   logic       rd_stb_reg;
   logic       rd_stb_next;
   logic       ee_reg;
   logic       ee_next;

   function automatic logic addr_match(input logic [7:0] b,
                                       input logic [2:0] sel);
      addr_match = (b[7:4] == DEV_ID) && (b[3:1] == sel);
   endfunction

   logic start_cond;
   logic stop_cond;
   // scl must be high in both stages, so a data change made together
   // with the scl fall is not taken for a start or a stop
   assign start_cond = sda_fall & scl_lvl & ~scl_fall;
   assign stop_cond  = sda_rise & scl_lvl & ~scl_fall;

   always_comb begin
      state_next      = state_reg;
      bit_next        = bit_reg;
      shift_next      = shift_reg;
      ack_next        = ack_reg;
      sda_oe_next     = sda_oe_reg;
      wr_stb_next     = 1'b0;
      wr_data_next    = wr_data_reg;
      first_next      = first_reg;
      first_pend_next = first_pend_reg;
      rd_stb_next     = 1'b0;
      ee_next         = 1'b0;
      if (start_cond) begin
         // start or repeated start reopens address phase
         state_next  = ST_ADDR;
         bit_next    = twi_pkg::BIT_FIRST;
         sda_oe_next = 1'b0;
      end else if (stop_cond) begin
         state_next  = ST_IDLE;
         sda_oe_next = 1'b0;
      end else begin
         case (state_reg)
            ST_ADDR, ST_RX: begin
               if (scl_rise) begin
                  shift_next = {shift_reg[6:0], sda_lvl};
                  bit_next   = bit_reg + 4'h1;
               end
               if (scl_fall && bit_reg == twi_pkg::BIT_ACK) begin
                  bit_next = twi_pkg::BIT_FIRST;
                  if (state_reg == ST_ADDR) begin
                     if (!addr_match(shift_reg, address_select_bits_i)) begin
                        state_next = ST_IGNORE;
                     end else if (eeprom_busy_i) begin
                        state_next = ST_IGNORE;
                     end else begin
                        sda_oe_next     = 1'b1;
                        ack_next        = shift_reg[0];
                        first_pend_next = 1'b1;
                        state_next      = ST_ACK_RX;
                     end
                  end else if (eeprom_busy_i) begin
                     state_next = ST_IGNORE;
                  end else begin
                     sda_oe_next  = 1'b1;
                     wr_stb_next  = 1'b1;
                     wr_data_next = shift_reg;
                     first_next   = first_pend_reg;
                     first_pend_next = 1'b0;
                     ee_next      = ~eeprom_write_control_i;
                     ack_next     = 1'b0;
                     state_next   = ST_ACK_RX;
                  end
               end
            end
            ST_ACK_RX: begin
               // release only after the ack pulse falls
               if (scl_fall) begin
                  if (ack_reg) begin
                     shift_next  = rd_data_i;
                     rd_stb_next = 1'b1;
                     sda_oe_next = ~rd_data_i[7];
                     state_next  = ST_TX;
                  end else begin
                     sda_oe_next = 1'b0;
                     state_next  = ST_RX;
                  end
               end
            end
            ST_TX: begin
               if (scl_fall) begin
                  if (bit_reg == twi_pkg::BIT_LAST) begin
                     sda_oe_next = 1'b0;
                     bit_next    = twi_pkg::BIT_FIRST;
                     state_next  = ST_ACK_TX;
                  end else begin
                     shift_next  = {shift_reg[6:0], 1'b0};
                     sda_oe_next = ~shift_reg[6];
                     bit_next    = bit_reg + 4'h1;
                  end
               end
            end
            ST_ACK_TX: begin
               if (scl_rise) begin
                  ack_next = sda_lvl;
               end
               if (scl_fall) begin
                  if (ack_reg) begin
                     state_next = ST_IGNORE;
                  end else begin
                     shift_next  = rd_data_i;
                     rd_stb_next = 1'b1;
                     sda_oe_next = ~rd_data_i[7];
                     state_next  = ST_TX;
                  end
               end
            end
            ST_IGNORE: begin
               sda_oe_next = 1'b0;
            end
            default: begin
               state_next  = ST_IDLE;
               sda_oe_next = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         state_reg      <= ST_IDLE;
         bit_reg        <= twi_pkg::BIT_FIRST;
         shift_reg      <= 8'h00;
         ack_reg        <= 1'b0;
         sda_oe_reg     <= 1'b0;
         wr_stb_reg     <= 1'b0;
         wr_data_reg    <= 8'h00;
         first_reg      <= 1'b0;
         first_pend_reg <= 1'b0;
         rd_stb_reg     <= 1'b0;
         ee_reg         <= 1'b0;
      end else begin
         state_reg      <= state_next;
         bit_reg        <= bit_next;
         shift_reg      <= shift_next;
         ack_reg        <= ack_next;
         sda_oe_reg     <= sda_oe_next;
         wr_stb_reg     <= wr_stb_next;
         wr_data_reg    <= wr_data_next;
         first_reg      <= first_next;
         first_pend_reg <= first_pend_next;
         rd_stb_reg     <= rd_stb_next;
         ee_reg         <= ee_next;
      end
   end

   // no scl output exists; sda is open drain, driven only low
   assign sda_o          = 1'b0;
   assign sda_oe_o       = sda_oe_reg;
   assign wr_stb_o       = wr_stb_reg;
   assign wr_data_o      = wr_data_reg;
   assign first_o        = first_reg;
   assign rd_stb_o       = rd_stb_reg;
   assign eeprom_start_o = ee_reg;
endmodule
`default_nettype wire

// *** twi_checker.sv ***
// concurrent checks on the two-wire slave port
`timescale 1ns/1ps
`default_nettype none
module twi_checker (
   // clock and reset
   input wire logic sys_clk_i,
   input wire logic rst_i,
   // bus and side ports
   input wire logic scl_i,
   input wire logic sda_o,
   input wire logic sda_oe_o,
   input wire logic eeprom_write_control_i,
   input wire logic eeprom_busy_i,
   input wire logic wr_stb_o,
   input wire logic rd_stb_o,
   input wire logic eeprom_start_o
);
   // ------------------------------------------------------------
   // properties
   // ------------------------------------------------------------
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (rst_i);
   sequence pull_held;
      sda_oe_o [*8];
   endsequence
   a_open_drain: assert property (sda_o == 1'b0)
      else $error("sda value not low");
   a_ack_hold: assert property ($rose(sda_oe_o) |-> pull_held)
      else $error("pull dropped early");
   a_sda_change_low: assert property ($changed(sda_oe_o) |-> !scl_i)
      else $error("sda moved with scl high");
   a_write_acked: assert property (wr_stb_o |-> $rose(sda_oe_o))
      else $error("write without ack");
   a_wr_pulse: assert property (wr_stb_o |=> !wr_stb_o)
      else $error("write strobe too long");
   a_rd_pulse: assert property (rd_stb_o |-> !scl_i ##1 !rd_stb_o)
      else $error("read strobe bad");
   a_ee_pair: assert property (eeprom_start_o |->
      wr_stb_o && !eeprom_write_control_i)
      else $error("eeprom start unexpected");
   a_ee_when: assert property (wr_stb_o && !eeprom_write_control_i
      |-> eeprom_start_o)
      else $error("eeprom start missing");
   a_busy_nack: assert property ($rose(sda_oe_o) |->
      !$past(eeprom_busy_i, 1))
      else $error("ack while busy");
endmodule
bind two_wire_slave_port twi_checker twi_checker_i (
   .sys_clk_i(sys_clk_i), .rst_i(rst_i), .scl_i(scl_i), .sda_o(sda_o),
   .sda_oe_o(sda_oe_o), .eeprom_write_control_i(eeprom_write_control_i),
   .eeprom_busy_i(eeprom_busy_i), .wr_stb_o(wr_stb_o), .rd_stb_o(rd_stb_o),
   .eeprom_start_o(eeprom_start_o));
`default_nettype wire

// *** twi_master.sv ***
// behavioural two-wire bus master driving scl and the data line
`timescale 1ns/1ps
`default_nettype none
module twi_master (
   input  wire logic sys_clk_i,
   input  wire logic sda_oe_i,
   output logic      scl_o,
   output logic      sda_o
);
   // ------------------------------------------------------------
   // bus master
   // ------------------------------------------------------------
   logic pull_low = 1'b0;
   // default half period of 4 system cycles gives a 32 ns link clock
   int   half     = 4;
   initial scl_o = 1'b1;
   // pull-up: line low when either party pulls
   assign sda_o = !(pull_low || sda_oe_i);
   task automatic hw(input int n);
      repeat (n) @(negedge sys_clk_i);
   endtask
   task automatic start;
      hw(half / 4);
      pull_low = 1'b0;
      hw(half);
      scl_o = 1'b1;
      hw(half);
      pull_low = 1'b1;
      hw(half);
      scl_o = 1'b0;
   endtask
   task automatic stop;
      hw(half / 4);
      pull_low = 1'b1;
      hw(half);
      scl_o = 1'b1;
      hw(half);
      pull_low = 1'b0;
      hw(half);
   endtask
   // byte then ack slot, msb first; a one releases the line
   task automatic xfer(input logic [8:0] d, output logic [8:0] q);
      for (int i = 8; i >= 0; i--) begin
         // hold the data a little past the scl fall
         hw(half / 4);
         pull_low = !d[i];
         hw(half - half / 4);
         scl_o = 1'b1;
         hw(half / 2);
         q[i] = sda_o;
         hw(half - half / 2);
         scl_o = 1'b0;
      end
   endtask
endmodule
`default_nettype wire

// *** test_two_wire_slave_port.sv ***
// self-checking bench for the two-wire slave port
`timescale 1ns/1ps
`default_nettype none
module test_two_wire_slave_port;
   // ------------------------------------------------------------
   // bench
   // ------------------------------------------------------------
   logic       sys_clk_i = 1'b0;
   logic       rst_i     = 1'b1;
   logic [2:0] sel       = 3'h5;
   logic       wc        = 1'b0;
   logic       busy      = 1'b0;
   logic [7:0] rd_data   = 8'hc4;
   wire logic  scl, sda, sda_oe, wr_stb, first, rd_stb, ee_start;
   wire logic [7:0] wr_data;
   logic [9:0] wlog[$];
   logic [8:0] q;
   int errors = 0;
   int checks = 0;
   int rds    = 0;
   int cycles = 0;
   always #2 sys_clk_i = ~sys_clk_i;
   two_wire_slave_port two_wire_slave_port_i (
      .sys_clk_i(sys_clk_i), .rst_i(rst_i), .scl_i(scl), .sda_i(sda),
      .sda_o(), .sda_oe_o(sda_oe), .address_select_bits_i(sel),
      .eeprom_write_control_i(wc), .eeprom_busy_i(busy),
      .wr_stb_o(wr_stb), .wr_data_o(wr_data), .first_o(first),
      .rd_stb_o(rd_stb), .rd_data_i(rd_data), .eeprom_start_o(ee_start));
   twi_master twi_master_i (
      .sys_clk_i(sys_clk_i), .sda_oe_i(sda_oe), .scl_o(scl), .sda_o(sda));
   always @(negedge sys_clk_i) begin
      cycles <= cycles + 1;
      if (wr_stb) wlog.push_back({first, ee_start, wr_data});
      if (rd_stb) rds <= rds + 1;
      if (cycles == 60000) begin
         errors++;
         end_sim();
      end
   end
   function automatic logic [8:0] adr(input logic [2:0] a, input logic r);
      return {twi_pkg::DEV_ID_DEFAULT, a, r, 1'b1};
   endfunction
   task automatic cmp(input logic [9:0] got, input logic [9:0] exp);
      checks++;
      if (got !== exp) begin
         errors++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task automatic t_write;
      twi_master_i.start();
      twi_master_i.xfer(adr(3'h5, 1'b0), q);
      cmp(q[0], 1'b0);
      twi_master_i.xfer({8'h3c, 1'b1}, q);
      cmp(q[0], 1'b0);
      twi_master_i.xfer({8'hc3, 1'b1}, q);
      cmp(q[0], 1'b0);
      twi_master_i.stop();
      cmp(10'(wlog.size()), 10'h2);
      cmp(wlog.pop_front(), {2'b11, 8'h3c});
      cmp(wlog.pop_front(), {2'b01, 8'hc3});
   endtask
   task automatic t_read;
      wc = 1'b1;
      twi_master_i.start();
      twi_master_i.xfer(adr(3'h5, 1'b0), q);
      twi_master_i.xfer({8'h07, 1'b1}, q);
      cmp(wlog.pop_front(), {2'b10, 8'h07});
      rds = 0;
      twi_master_i.start();
      twi_master_i.xfer(adr(3'h5, 1'b1), q);
      cmp(q[0], 1'b0);
      twi_master_i.xfer(9'h1fe, q);
      rd_data = 8'h5a;
      cmp(q, 9'h188);
      twi_master_i.xfer(9'h1ff, q);
      rd_data = 8'h00;
      cmp(q, 9'h0b5);
      twi_master_i.hw(4);
      cmp(sda, 1'b1);
      cmp(10'(rds), 10'h2);
      twi_master_i.stop();
   endtask
   task automatic t_busy;
      int rate_half[2];
      int link_half;
      rate_half[0] = twi_pkg::FAST_HALF_CYC;
      rate_half[1] = (twi_pkg::SYS_CLK_MHZ * 1000) /
                     (twi_pkg::STD_RATE_KHZ * 2);
      link_half    = twi_master_i.half;
      busy = 1'b1;
      twi_master_i.start();
      twi_master_i.xfer(adr(3'h5, 1'b0), q);
      cmp(q[0], 1'b1);
      twi_master_i.stop();
      busy = 1'b0;
      foreach (rate_half[k]) begin
         twi_master_i.half = rate_half[k];
         twi_master_i.start();
         twi_master_i.xfer(adr(3'h5, 1'b0), q);
         cmp(q[0], 1'b0);
         twi_master_i.stop();
      end
      twi_master_i.half = link_half;
   endtask
   task automatic t_mismatch;
      sel = 3'h6;
      twi_master_i.start();
      twi_master_i.xfer(adr(3'h5, 1'b0), q);
      cmp(q[0], 1'b1);
      twi_master_i.xfer({8'h00, 1'b1}, q);
      cmp(q[0], 1'b1);
      twi_master_i.stop();
      cmp(10'(wlog.size()), 10'h0);
   endtask
   task automatic end_sim;
      if (errors == 0 && checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   initial begin
      repeat (8) @(negedge sys_clk_i);
      rst_i = 1'b0;
      repeat (4) @(negedge sys_clk_i);
      t_write();
      t_read();
      t_busy();
      t_mismatch();
      end_sim();
   end
endmodule
`default_nettype wire
